// [hw/wmo_pkg.sv]
// constants, field layout and state codes of the write merge / ordering unit
// assumes one clock domain; every user writes wmo_pkg::name
// Functional notes
// R1 - eight-byte merge buffer combines noncacheable writes
// R2 - global disable: no ordering, empty input ignored
// R3 - speculative disable: order all but uncacheable/combining
// R4 - speculative mode waits for empty input asserted
// R5 - full mode orders merge buffer before cache
// R6 - full mode: flush, then wait empty input
// R7 - reset clears both ordering-disable bits
// R8 - system holds empty input negated until done
// R9 - range zero low word, range one high
// R10 - uncacheable: no read or write allocation
// R11 - combining: no read allocation, writes merged
// R12 - base holds top 15 address bits
// R13 - match when masked base equals masked address
// R14 - nocache flag wins; combine alone means combining
// R15 - flags at bits 1,0 and 33,32
// R16 - range register at its index, resets zero
// R17 - software keeps ranges aligned, masks contiguous
// R18 - trailing zero mask bits double range size
// R19 - overlap with any nocache match is uncacheable
package wmo_pkg;
  localparam logic [31:0] RTC_IDX = 32'hC000_0085;
  localparam logic [63:0] RTC_RST = 64'h0;
  localparam int RNG_W = 32;
  localparam int UC_BIT = 0;
  localparam int WC_BIT = 1;
  localparam int MASK_LSB = 2;
  localparam int BASE_LSB = 17;
  localparam int FLD_W = 15;
  localparam logic [1:0] ORD_RST = 2'h0;
  localparam int ORD_GLOBAL = 1;
  localparam int ORD_SPEC = 0;
  localparam int QW_LSB = 3;
  localparam int MB_BYTES = 8;
  typedef enum logic [1:0] {
    WMO_IDLE = 2'b00,
    WMO_BUS = 2'b01,
    WMO_EXT_WRITE_BUF_EMPTY_N = 2'b10
  } wmo_st_e;
endpackage

// [hw/wmo_ifs.sv]
// carriers between the unit and its range classifier and merge buffer
// assumes clk and nrst are those of the top module
`timescale 1ns/1ns
interface wmo_cls_if (
  input wire logic clk,
  input wire logic nrst
);
  logic [63:0] rtc;
  logic [31:0] addr;
  logic uc;
  logic wc;
  modport cls (input clk, input nrst, input rtc, input addr, output uc, output wc);
  modport user (output rtc, output addr, input uc, input wc);
endinterface

interface wmo_mb_if (
  input wire logic clk,
  input wire logic nrst
);
  logic load;
  logic clear;
  logic [28:0] tag_in;
  logic [63:0] data_in;
  logic [7:0] be_in;
  logic valid;
  logic can_merge;
  logic [28:0] tag;
  logic [63:0] data;
  logic [7:0] be;
  modport buf_side (input clk, input nrst, input load, input clear, input tag_in, input data_in,
    input be_in, output valid, output can_merge, output tag, output data, output be);
  modport user (output load, output clear, output tag_in, output data_in, output be_in,
    input valid, input can_merge, input tag, input data, input be);
endinterface

// [hw/wmo_classify.sv]
// two-range memory type decode of one physical address
// assumes software programs aligned ranges with contiguous masks
`timescale 1ns/1ns
module wmo_classify (
  wmo_cls_if.cls c
);
  logic [1:0] hit_uc;
  logic [1:0] hit_wc;

  // R12 base is the top 15 bits, low 17 taken as zero
  // R18 trailing zero mask bits widen the compare window
  function automatic logic in_range(input logic [31:0] desc, input logic [31:0] a);
    logic [14:0] m;
    m = desc[wmo_pkg::MASK_LSB +: wmo_pkg::FLD_W];
    in_range = (m & desc[wmo_pkg::BASE_LSB +: wmo_pkg::FLD_W]) == (m & a[31:17]);
  endfunction

  // R9 two ranges
  for (genvar i = 0; i < 2; i++) begin : g_rng
    logic [31:0] desc;
    logic hit;
    assign desc = c.rtc[i * wmo_pkg::RNG_W +: wmo_pkg::RNG_W];
    // R13 masked compare
    assign hit = in_range(desc, c.addr);
    // R14 R15 flag decode at bits 1,0 of each half
    assign hit_uc[i] = hit & desc[wmo_pkg::UC_BIT];
    assign hit_wc[i] = hit & desc[wmo_pkg::WC_BIT] & ~desc[wmo_pkg::UC_BIT];
  end

  // R19 uncacheable wins on overlap
  assign c.uc = |hit_uc;
  assign c.wc = (|hit_wc) & ~(|hit_uc);

  type_excl_a: assert property (@(posedge c.clk) disable iff (!c.nrst) !(c.uc && c.wc)) // R19
    else $error("address typed both uncacheable and combining");
  r0_nocache_a: assert property (@(posedge c.clk) disable iff (!c.nrst) // R14
    (c.rtc[wmo_pkg::UC_BIT] && ((c.rtc[16:2] & c.rtc[31:17]) == (c.rtc[16:2] & c.addr[31:17]))) |-> c.uc)
    else $error("range zero nocache match not uncacheable");
endmodule

// [hw/wmo_merge_buf.sv]
// eight-byte write merge buffer, one aligned quadword
// assumes load and clear are never raised together
`timescale 1ns/1ns
module wmo_merge_buf (
  wmo_mb_if.buf_side m
);
  typedef struct packed {
    logic valid;
    logic [28:0] tag;
    logic [63:0] data;
    logic [7:0] be;
  } wmo_mb_s;

  wmo_mb_s q;
  wmo_mb_s d;
  logic [63:0] wdata;
  logic [7:0] wbe;

  // R1 byte lanes merge over older bytes
  for (genvar b = 0; b < wmo_pkg::MB_BYTES; b++) begin : g_lane
    assign wdata[b * 8 +: 8] = m.be_in[b] ? m.data_in[b * 8 +: 8] : (q.valid ? q.data[b * 8 +: 8] : 8'h00);
    assign wbe[b] = m.be_in[b] | (q.valid & q.be[b]);
  end

  always_comb begin
    d = q;
    if (m.clear) begin
      d = '0;
    end else if (m.load) begin
      d.valid = 1'b1;
      d.tag = m.tag_in;
      d.data = wdata;
      d.be = wbe;
    end
  end

  always_ff @(posedge m.clk or negedge m.nrst) begin
    if (!m.nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign m.valid = q.valid;
  assign m.can_merge = !q.valid || (q.tag == m.tag_in);
  assign m.tag = q.tag;
  assign m.data = q.data;
  assign m.be = q.be;

  merge_keep_a: assert property (@(posedge m.clk) disable iff (!m.nrst) // R1
    (m.load && !m.clear) |=> (m.valid && m.tag == $past(m.tag_in) && ((m.be & $past(m.be_in)) == $past(m.be_in))))
    else $error("merged bytes not held in buffer");
  merge_two_c: cover property (@(posedge m.clk) disable iff (!m.nrst) m.load ##1 m.load);
endmodule

// [hw/wmo_top.sv]
// write merge, write ordering and range typing unit of the processor
// assumes write requests stay stable until wr_done; bus writes held until ack
`timescale 1ns/1ns
module wmo_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic msr_wr_en,
  input wire logic msr_rd_en,
  input wire logic [31:0] msr_addr,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata,
  output logic msr_hit,
  input wire logic ord_wr_en,
  input wire logic [1:0] ord_wdata,
  output logic [1:0] write_order_control,
  input wire logic wr_valid,
  input wire logic [31:0] wr_addr,
  input wire logic [63:0] wr_data,
  input wire logic [7:0] wr_be,
  input wire logic wr_hit_me,
  output logic wr_done,
  output logic cache_commit,
  input wire logic [31:0] rd_addr,
  output logic rd_no_alloc,
  input wire logic ext_write_buf_empty_n,
  output logic bus_wr_req,
  output logic [31:0] bus_wr_addr,
  output logic [63:0] bus_wr_data,
  output logic [7:0] bus_wr_be,
  input wire logic bus_wr_ack
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    wmo_pkg::wmo_st_e st;
    logic [63:0] rtc;
    logic [1:0] ord;
    logic done;
    logic commit;
    logic bus_req;
    logic bus_direct;
    logic [31:0] bus_addr;
    logic [63:0] bus_data;
    logic [7:0] bus_be;
    logic [63:0] rdata;
    logic rhit;
    logic no_alloc;
  } wmo_state_s;

  wmo_state_s q;
  wmo_state_s d;
  logic gdis;
  logic sdis;
  logic take;

  function automatic logic is_rtc(input logic [31:0] a);
    is_rtc = (a == wmo_pkg::RTC_IDX);
  endfunction

  // ****************************************
  // sub-blocks
  // ****************************************
  wmo_cls_if wcls (.clk(clk), .nrst(nrst));
  wmo_cls_if rcls (.clk(clk), .nrst(nrst));
  wmo_mb_if mb (.clk(clk), .nrst(nrst));

  assign wcls.rtc = q.rtc;
  assign wcls.addr = wr_addr;
  assign rcls.rtc = q.rtc;
  assign rcls.addr = rd_addr;

  wmo_classify u_wcls (.c(wcls));
  wmo_classify u_rcls (.c(rcls));
  wmo_merge_buf u_mb (.m(mb));

  assign mb.tag_in = wr_addr[31:wmo_pkg::QW_LSB];
  assign mb.data_in = wr_data;
  assign mb.be_in = wr_be;

  // R2 global disable overrides the speculative bit
  assign gdis = q.ord[wmo_pkg::ORD_GLOBAL];
  assign sdis = q.ord[wmo_pkg::ORD_SPEC] & ~gdis;
  // done is still high in the cycle the requester sees it, so that cycle is skipped
  assign take = wr_valid & ~q.done;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.commit = 1'b0;
    mb.load = 1'b0;
    mb.clear = 1'b0;
    // R16 register write at its index
    if (msr_wr_en && is_rtc(msr_addr)) begin
      d.rtc = msr_wdata;
    end
    if (ord_wr_en) begin
      d.ord = ord_wdata;
    end
    d.rhit = msr_rd_en & is_rtc(msr_addr);
    d.rdata = (msr_rd_en && is_rtc(msr_addr)) ? q.rtc : 64'h0;
    // R10 R11 reads of typed ranges skip line allocation
    d.no_alloc = rcls.uc | rcls.wc;
    case (q.st)
      wmo_pkg::WMO_IDLE: begin
        if (take && wr_hit_me) begin
          if (!gdis && !sdis && mb.valid) begin
            // R5 merged data must reach the bus before a cache commit
            d.bus_req = 1'b1;
            d.bus_direct = 1'b0;
            d.bus_addr = {mb.tag, 3'h0};
            d.bus_data = mb.data;
            d.bus_be = mb.be;
            mb.clear = 1'b1;
            d.st = wmo_pkg::WMO_BUS;
          end else if (gdis || !ext_write_buf_empty_n) begin
            // R2 empty input ignored under global disable
            d.commit = 1'b1;
            d.done = 1'b1;
          end else begin
            // R4 R6 hold commit until the system reports empty
            d.st = wmo_pkg::WMO_EXT_WRITE_BUF_EMPTY_N;
          end
        end else if (take && wcls.wc) begin
          if (mb.can_merge) begin
            // R11 combinable write joins the buffer
            mb.load = 1'b1;
            d.done = 1'b1;
          end else begin
            d.bus_req = 1'b1;
            d.bus_direct = 1'b0;
            d.bus_addr = {mb.tag, 3'h0};
            d.bus_data = mb.data;
            d.bus_be = mb.be;
            mb.clear = 1'b1;
            d.st = wmo_pkg::WMO_BUS;
          end
        end else if (take) begin
          // R3 in speculative mode uncacheable writes may pass the buffer
          if (mb.valid && !gdis && !(sdis && wcls.uc)) begin
            d.bus_req = 1'b1;
            d.bus_direct = 1'b0;
            d.bus_addr = {mb.tag, 3'h0};
            d.bus_data = mb.data;
            d.bus_be = mb.be;
            mb.clear = 1'b1;
          end else begin
            // R10 uncacheable write goes straight out, no allocation
            d.bus_req = 1'b1;
            d.bus_direct = 1'b1;
            d.bus_addr = wr_addr;
            d.bus_data = wr_data;
            d.bus_be = wr_be;
          end
          d.st = wmo_pkg::WMO_BUS;
        end else if (mb.valid && !q.done) begin
          // idle drain keeps merged data from sitting forever
          d.bus_req = 1'b1;
          d.bus_direct = 1'b0;
          d.bus_addr = {mb.tag, 3'h0};
          d.bus_data = mb.data;
          d.bus_be = mb.be;
          mb.clear = 1'b1;
          d.st = wmo_pkg::WMO_BUS;
        end
      end
      wmo_pkg::WMO_BUS: begin
        if (bus_wr_ack) begin
          d.bus_req = 1'b0;
          d.done = q.bus_direct;
          d.st = wmo_pkg::WMO_IDLE;
        end
      end
      wmo_pkg::WMO_EXT_WRITE_BUF_EMPTY_N: begin
        // R4 R6 R8 commit once the empty input is seen asserted
        if (gdis || !ext_write_buf_empty_n) begin
          d.commit = 1'b1;
          d.done = 1'b1;
          d.st = wmo_pkg::WMO_IDLE;
        end
      end
      default: begin
        d.st = wmo_pkg::WMO_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.st <= wmo_pkg::WMO_IDLE;
      // R16 range register clears
      q.rtc <= wmo_pkg::RTC_RST;
      // R7 full ordering after reset
      q.ord <= wmo_pkg::ORD_RST;
    end else begin
      q <= d;
    end
  end

  assign msr_rdata = q.rdata;
  assign msr_hit = q.rhit;
  assign write_order_control = q.ord;
  assign wr_done = q.done;
  assign cache_commit = q.commit;
  assign rd_no_alloc = q.no_alloc;
  assign bus_wr_req = q.bus_req;
  assign bus_wr_addr = q.bus_addr;
  assign bus_wr_data = q.bus_data;
  assign bus_wr_be = q.bus_be;

  // ****************************************
  // checks
  // ****************************************
  reset_clear_a: assert property (@(posedge clk) $rose(nrst) |-> (q.ord == 2'h0 && q.rtc == 64'h0)) // R7
    else $error("ordering bits or range register not clear after reset");
  rtc_write_a: assert property (@(posedge clk) disable iff (!nrst) // R16
    (msr_wr_en && msr_addr == wmo_pkg::RTC_IDX) |=> (q.rtc == $past(msr_wdata)))
    else $error("range register write lost");
  rtc_read_a: assert property (@(posedge clk) disable iff (!nrst) // R16
    (msr_rd_en && msr_addr == wmo_pkg::RTC_IDX && !msr_wr_en) |=> (msr_hit && msr_rdata == $past(q.rtc)))
    else $error("range register read wrong");
  global_fast_a: assert property (@(posedge clk) disable iff (!nrst) // R2
    (q.st == wmo_pkg::WMO_IDLE && take && wr_hit_me && gdis && !ord_wr_en) |=> (cache_commit && wr_done))
    else $error("global disable did not commit at once");
  ext_write_buf_empty_n_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R4
    (q.st == wmo_pkg::WMO_EXT_WRITE_BUF_EMPTY_N && ext_write_buf_empty_n && !gdis) |=> !cache_commit)
    else $error("commit while write buffer not empty");
  commit_empty_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    (cache_commit && !$past(gdis)) |-> !$past(ext_write_buf_empty_n))
    else $error("ordered commit without empty indication");
  full_flush_a: assert property (@(posedge clk) disable iff (!nrst) // R5
    (cache_commit && $past(q.ord) == 2'h0) |-> !$past(mb.valid))
    else $error("cache commit ahead of merged data");
  bus_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R1
    (bus_wr_req && !bus_wr_ack) |=> (bus_wr_req && $stable(bus_wr_addr) && $stable(bus_wr_data)))
    else $error("bus write dropped before ack");
  read_alloc_a: assert property (@(posedge clk) disable iff (!nrst) // R10
    (rcls.uc || rcls.wc) |=> rd_no_alloc)
    else $error("typed read allowed allocation");
  wait_ext_write_buf_empty_n_c: cover property (@(posedge clk) disable iff (!nrst)
    q.st == wmo_pkg::WMO_EXT_WRITE_BUF_EMPTY_N ##1 q.st == wmo_pkg::WMO_EXT_WRITE_BUF_EMPTY_N ##1 cache_commit);
  flush_then_commit_c: cover property (@(posedge clk) disable iff (!nrst)
    (bus_wr_req && !q.bus_direct) ##[1:20] cache_commit);
  direct_write_c: cover property (@(posedge clk) disable iff (!nrst) bus_wr_req && q.bus_direct && bus_wr_ack);
endmodule

// [tb/wmo_sys_model.sv]
// system-side model: acknowledges bus writes and drives the write-buffer-empty input
// assumes bus_wr_req is held until acknowledged
`timescale 1ns/1ns
module wmo_sys_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_wr_req,
  input wire logic hold,
  input wire logic [3:0] ack_dly,
  output logic bus_wr_ack,
  output logic ext_write_buf_empty_n
);
  logic [3:0] wait_q;
  logic [2:0] tail_q;
  // ****************************************
  // acknowledge and empty indication
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_wr_ack <= 1'b0;
      wait_q <= 4'h0;
      tail_q <= 3'h0;
      ext_write_buf_empty_n <= 1'b1;
    end else begin
      bus_wr_ack <= 1'b0;
      if (bus_wr_req && !bus_wr_ack) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= ack_dly) begin
          bus_wr_ack <= 1'b1;
          wait_q <= 4'h0;
        end
      end
      // negated until done
      // a short tail after the ack mimics the external write still draining
      tail_q <= (bus_wr_req || bus_wr_ack) ? 3'h3 : ((tail_q != 3'h0) ? tail_q - 3'h1 : 3'h0);
      ext_write_buf_empty_n <= hold || bus_wr_req || bus_wr_ack || (tail_q != 3'h0);
    end
  end
endmodule

// [tb/wmo_top_tb.sv]
// self-checking bench of the write merge, ordering and range typing unit
// assumes wmo_sys_model stands in for the system logic
`timescale 1ns/1ns
module wmo_top_tb;
  // ****************************************
  // stimulus and observation
  // ****************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic msr_wr_en = 1'b0, msr_rd_en = 1'b0, ord_wr_en = 1'b0, wr_valid = 1'b0, wr_hit_me = 1'b0, hold = 1'b0;
  logic [31:0] msr_addr = 32'h0, wr_addr = 32'h0, rd_addr = 32'h0, bus_wr_addr, cap_addr;
  logic [63:0] msr_wdata = 64'h0, wr_data = 64'h0, msr_rdata, bus_wr_data, cap_data;
  logic [7:0] wr_be = 8'h0, bus_wr_be, cap_be;
  logic [1:0] ord_wdata = 2'h0, write_order_control;
  logic [3:0] ack_dly = 4'h3;
  logic msr_hit, wr_done, cache_commit, rd_no_alloc, ext_write_buf_empty_n, bus_wr_req, bus_wr_ack;
  logic na, cm;
  int n_mismatch = 0, n_tests = 0, n_bus = 0, cyc_cnt = 0, cyc;
  always #4 clk = ~clk;
  wmo_top wmo_top_inst (.*);
  wmo_sys_model wmo_sys_model_inst (.*);
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (bus_wr_req === 1'b1 && bus_wr_ack === 1'b1) begin
      cap_addr <= bus_wr_addr;
      cap_data <= bus_wr_data;
      cap_be <= bus_wr_be;
      n_bus <= n_bus + 1;
    end
    if (cyc_cnt == 6000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] rng(logic [14:0] base, logic [14:0] mask, logic wc, logic uc);
    return {base, mask, wc, uc};
  endfunction
  task automatic msr_write(logic [31:0] a, logic [63:0] v);
    @(posedge clk);
    msr_wr_en <= 1'b1;
    msr_addr <= a;
    msr_wdata <= v;
    @(posedge clk);
    msr_wr_en <= 1'b0;
  endtask
  task automatic msr_read(logic [31:0] a);
    @(posedge clk);
    msr_rd_en <= 1'b1;
    msr_addr <= a;
    @(posedge clk);
    msr_rd_en <= 1'b0;
    #1;
  endtask
  task automatic set_order(logic [1:0] v);
    @(posedge clk);
    ord_wr_en <= 1'b1;
    ord_wdata <= v;
    @(posedge clk);
    ord_wr_en <= 1'b0;
    #1;
  endtask
  task automatic read_type(logic [31:0] a);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    #1 na = rd_no_alloc;
  endtask
  // the request is held until wr_done is seen, then dropped on that same edge
  task automatic do_write(logic [31:0] a, logic [63:0] d, logic [7:0] be, logic hit);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    wr_be <= be;
    wr_hit_me <= hit;
    cyc = 0;
    while (wr_done !== 1'b1 && cyc < 200) begin
      @(posedge clk);
      cyc++;
    end
    cm = cache_commit;
    wr_valid <= 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    msr_read(wmo_pkg::RTC_IDX);
    check("reset hit", msr_hit, 1);
    check("reset value", msr_rdata, wmo_pkg::RTC_RST);
    check("reset order", write_order_control, 0);
    msr_write(wmo_pkg::RTC_IDX, 64'hA5A5_0003_5A5A_F001);
    msr_write(wmo_pkg::RTC_IDX + 32'h1, 64'h1);
    msr_read(wmo_pkg::RTC_IDX);
    check("readback", msr_rdata, 64'hA5A5_0003_5A5A_F001);
    msr_read(wmo_pkg::RTC_IDX + 32'h1);
    check("unmapped hit", msr_hit, 0);
    check("unmapped data", msr_rdata, 0);
    $display("test reset and register done");
  endtask
  // every range here is aligned to its size and uses a contiguous mask
  task automatic t_types();
    for (int f = 0; f < 4; f++) begin
      msr_write(wmo_pkg::RTC_IDX, {32'h0, rng(15'h0080, 15'h7F80, f[1], f[0])});
      read_type(32'h0100_0040);
      check("type decode", na, f != 0);
      read_type(32'h0200_0000);
      check("outside", na, 0);
    end
    msr_write(wmo_pkg::RTC_IDX, {rng(15'h2000, 15'h7FC0, 1'b1, 1'b0), 32'h0});
    read_type(32'h407F_FFF8);
    check("range one top", na, 1);
    read_type(32'h4080_0000);
    check("range one end", na, 0);
    read_type(32'h3FFF_FFF8);
    check("below base", na, 0);
    $display("test range types done");
  endtask
  task automatic t_merge();
    int n0;
    n0 = n_bus;
    do_write(32'h4000_0208, 64'h1100_0000_0000_0022, 8'h81, 1'b0);
    check("merge done", cyc, 2);
    repeat (20) @(posedge clk);
    check("one flush", n_bus, n0 + 1);
    check("flush addr", cap_addr, 32'h4000_0208);
    check("flush be", cap_be, 8'h81);
    check("flush data", cap_data & 64'hFF00_0000_0000_00FF, 64'h1100_0000_0000_0022);
    $display("test merge done");
  endtask
  task automatic t_order();
    for (int m = 0; m < 4; m++) begin
      set_order(m[1:0]);
      check("order bits", write_order_control, m);
      hold <= 1'b1;
      fork
        begin
          repeat (30) @(posedge clk);
          hold <= 1'b0;
        end
      join_none
      do_write(32'h0010_0000, 64'h0, 8'hFF, 1'b1);
      check("commit", cm, 1);
      check("held back", cyc >= 30, !m[1]);
      repeat (32) @(posedge clk);
    end
    $display("test ordering done");
  endtask
  task automatic t_uc();
    set_order(2'b01);
    msr_write(wmo_pkg::RTC_IDX, {rng(15'h2000, 15'h7FC0, 1'b0, 1'b1), rng(15'h2000, 15'h7FC0, 1'b1, 1'b0)});
    read_type(32'h4000_0100);
    check("overlap no alloc", na, 1);
    hold <= 1'b1;
    do_write(32'h4000_0100, 64'h0123_4567_89AB_CDEF, 8'hFF, 1'b0);
    check("uc no commit", cm, 0);
    check("uc not ordered", cyc < 20, 1);
    check("uc addr", cap_addr, 32'h4000_0100);
    check("uc data", cap_data, 64'h0123_4567_89AB_CDEF);
    check("uc be", cap_be, 8'hFF);
    hold <= 1'b0;
    $display("test uncacheable overlap done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_types();
    t_merge();
    t_order();
    t_uc();
    final_report();
  end
endmodule
